/* dfp_defs.svh */
// constants of the ddr flash host port: command/address layout and timing
// assumes inclusion by bare name from every design file that needs a figure
`ifndef DFP_DEFS_SVH
`define DFP_DEFS_SVH
// command/address phase: three 16-bit words, six bytes
`define DFP_CA_WORDS 2'd3
`define DFP_CA_LAST 2'd2
`define DFP_CA_WIDTH 48
`define DFP_CA_RW_BIT 47
`define DFP_CA_SPACE_BIT 46
`define DFP_CA_LINEAR_BIT 45
`define DFP_ADDR_MSB 44
// initial_access_time, nanoseconds
`define DFP_INIT_ACCESS_NS 96
// fastest bus clock allowed for a multi-word program load, MHz
`define DFP_BURST_WR_MAX_MHZ 50
`define DFP_FIFO_DEPTH 16
`define DFP_WORD_WIDTH 16
`endif

/* dfp_pkg.sv */
// types shared by the ddr flash host port
// assumes dfp_defs.svh is visible to the files that import it
package dfp_pkg;
   // link-side transaction phases
   typedef enum logic [1:0]
   {
      DFP_CA    = 2'b00,
      DFP_LAT   = 2'b01,
      DFP_READ  = 2'b10,
      DFP_WRITE = 2'b11
   } dfp_state_t;
endpackage : dfp_pkg

/* dfp_fifo.sv */
// dual-clock fifo with gray-coded pointers, valid/ready on both sides
// assumes each side's reset is held until its clock has run a few edges
`timescale 1ns/1ps
module dfp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // write side
   input wire logic wClk,
   input wire logic wRst,
   input wire logic wValid,
   output logic wReady,
   input wire logic [WIDTH-1:0] wData,
   // read side
   input wire logic rClk,
   input wire logic rRst,
   output logic rValid,
   input wire logic rReady,
   output logic [WIDTH-1:0] rData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wPtr, next_wPtr, rPtr, next_rPtr;
   logic [AW:0] wGray, rGray, rGrayW1, rGrayW2, wGrayR1, wGrayR2;
   logic [AW:0] rPtrW, wPtrR;

   function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
      logic [AW:0] b;
      b = '0;
      b[AW] = g[AW];
      for (int i = AW - 1; i >= 0; i--)
         b[i] = b[i+1] ^ g[i];
      return b;
   endfunction : gray2bin

   assign wGray = wPtr ^ (wPtr >> 1);
   assign rGray = rPtr ^ (rPtr >> 1);
   assign rPtrW = gray2bin(rGrayW2);
   assign wPtrR = gray2bin(wGrayR2);
   // full: write pointer a whole lap ahead of the synced read pointer
   assign wReady = (wPtr - rPtrW) != (AW+1)'(DEPTH);
   assign rValid = wPtrR != rPtr;
   assign rData = mem[rPtr[AW-1:0]];

   // pointer next values
   always_comb
   begin
      next_wPtr = wPtr + (AW+1)'(wValid && wReady);
      next_rPtr = rPtr + (AW+1)'(rValid && rReady);
   end

   // write side: storage, pointer and read-pointer synchroniser
   always_ff @(posedge wClk or posedge wRst)
   begin
      if (wRst)
      begin
         wPtr <= '0;
         rGrayW1 <= '0;
         rGrayW2 <= '0;
      end
      else
      begin
         wPtr <= next_wPtr;
         rGrayW1 <= rGray;
         rGrayW2 <= rGrayW1;
      end
   end

   always_ff @(posedge wClk)
   begin
      if (wValid && wReady)
         mem[wPtr[AW-1:0]] <= wData;
   end

   // read side: pointer and write-pointer synchroniser
   always_ff @(posedge rClk or posedge rRst)
   begin
      if (rRst)
      begin
         rPtr <= '0;
         wGrayR1 <= '0;
         wGrayR2 <= '0;
      end
      else
      begin
         rPtr <= next_rPtr;
         wGrayR1 <= wGray;
         wGrayR2 <= wGrayR1;
      end
   end

   chk_fifo_no_overfill: assert property (@(posedge wClk) disable iff (wRst)
      (wPtr - rPtrW) <= (AW+1)'(DEPTH))
      else $error("fifo holds more words than its depth");
endmodule : dfp_fifo

/* dfp_port.sv */
// device end of the eight-bit ddr flash host port
// assumes ckIn stops outside frames; frame logic runs on its falling edge
// and is cleared by chip select going high; the user side runs on clk.
`timescale 1ns/1ps
`include "dfp_defs.svh"
module dfp_port #(
   parameter int LINK_PERIOD_NS = 32,
   parameter int DEPTH = `DFP_FIFO_DEPTH
) (
   // core clock and reset
   input wire logic clk,
   input wire logic rst,
   // link pins
   input wire logic ckIn,
   input wire logic csN,
   input wire logic strobePhaseClock,
   input wire logic [7:0] dqIn,
   output logic [7:0] dqOut,
   output logic dqOe,
   output logic rwdsOut,
   output logic rwdsOe,
   // device state and mode levels
   input wire logic overlaySpaceState,
   input wire logic phaseShiftedStrobeMode,
   // decoded request towards the flash core
   output logic reqValid,
   output logic reqRead,
   output logic reqSpace,
   output logic reqLinear,
   output logic [`DFP_ADDR_MSB:0] reqAddr,
   output logic frameActive,
   output logic writeDrop,
   // read data from the flash core
   input wire logic rdValid,
   output logic rdReady,
   input wire logic [`DFP_WORD_WIDTH-1:0] rdData,
   // write data towards the flash core
   output logic wrValid,
   input wire logic wrReady,
   output logic [`DFP_WORD_WIDTH-1:0] wrData
);
   import dfp_pkg::*;
   // latency in whole link cycles, rounded down so data never comes late
   localparam int LAT_RAW = `DFP_INIT_ACCESS_NS / LINK_PERIOD_NS;
   localparam logic [3:0] LAT_CYCLES = 4'((LAT_RAW < 1) ? 1 : LAT_RAW);
   localparam int TW = `DFP_WORD_WIDTH + 1;

   // falling edge of the link clock runs the frame logic
   logic ckFall;
   assign ckFall = ~ckIn;

   logic [7:0] riseByte;
   logic [15:0] linkWord;
   dfp_state_t state, next_state;
   logic [3:0] cnt, next_cnt;
   logic [31:0] caShift, next_caShift;
   logic [15:0] outWord, next_outWord;
   logic dataPhase, next_dataPhase;
   logic wrAny, next_wrAny;
   logic ovl1, ovlLink, mode1, modeLink;
   logic reqToggle, next_reqToggle, dropToggle, next_dropToggle;
   logic [`DFP_CA_WIDTH-1:0] reqWord, next_reqWord;
   logic caDone, tagOk, popRd, pushWr, strobeClk, strobeEn;
   logic lrValid, lwReady;
   logic [TW-1:0] lrData;

   // first byte of each pair is sampled on the rising edge
   always_ff @(posedge ckIn)
   begin
      riseByte <= dqIn;
   end
   assign linkWord = {riseByte, dqIn};

   // read fifo words whose tag is not the current frame's are stale
   assign tagOk = lrData[TW-1] == reqToggle;
   assign caDone = (state == DFP_CA) && (cnt[1:0] == `DFP_CA_LAST);
   assign popRd = lrValid && (!tagOk || (state == DFP_READ));
   assign pushWr = (state == DFP_WRITE) && lwReady && !(wrAny && ovlLink);

   // frame state machine next values
   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      next_caShift = caShift;
      next_outWord = outWord;
      next_dataPhase = 1'b0;
      next_wrAny = wrAny;
      case (state)
         DFP_CA:
         begin
            next_caShift = {caShift[15:0], linkWord};
            next_cnt = cnt + 4'h1;
            if (caDone)
            begin
               next_cnt = 4'h1;
               next_state = caShift[31] ? DFP_LAT : DFP_WRITE;
               if (caShift[31] && LAT_CYCLES == 4'h1)
                  next_state = DFP_READ;
            end
         end
         DFP_LAT:
         begin
            next_cnt = cnt + 4'h1;
            if (cnt == LAT_CYCLES - 4'h1)
               next_state = DFP_READ;
         end
         DFP_READ:
         begin
            // a stall holds the strobe still rather than repeat a word
            if (lrValid && tagOk)
            begin
               next_outWord = lrData[TW-2:0];
               next_dataPhase = 1'b1;
            end
         end
         DFP_WRITE:
         begin
            next_wrAny = 1'b1;
         end
         default:
         begin
            next_state = DFP_CA;
         end
      endcase
   end

   // frame state ends with the frame itself
   always_ff @(posedge ckFall or posedge csN)
   begin
      if (csN)
      begin
         state <= DFP_CA;
         cnt <= 4'h0;
         caShift <= 32'h0;
         outWord <= 16'h0;
         dataPhase <= 1'b0;
         wrAny <= 1'b0;
         ovl1 <= 1'b0;
         ovlLink <= 1'b0;
         mode1 <= 1'b0;
         modeLink <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         caShift <= next_caShift;
         outWord <= next_outWord;
         dataPhase <= next_dataPhase;
         wrAny <= next_wrAny;
         ovl1 <= overlaySpaceState;
         ovlLink <= ovl1;
         mode1 <= phaseShiftedStrobeMode;
         modeLink <= mode1;
      end
   end

   // request word and event toggles outlive the frame
   always_comb
   begin
      next_reqWord = reqWord;
      next_reqToggle = reqToggle;
      next_dropToggle = dropToggle;
      if (caDone)
      begin
         next_reqWord = {caShift, linkWord};
         if (!caShift[31])
            next_reqWord[`DFP_CA_LINEAR_BIT] = 1'b1;
         next_reqToggle = ~reqToggle;
      end
      if ((state == DFP_WRITE) && !pushWr)
         next_dropToggle = ~dropToggle;
   end

   always_ff @(posedge ckFall or posedge rst)
   begin
      if (rst)
      begin
         reqWord <= '0;
         reqToggle <= 1'b0;
         dropToggle <= 1'b0;
      end
      else
      begin
         reqWord <= next_reqWord;
         reqToggle <= next_reqToggle;
         dropToggle <= next_dropToggle;
      end
   end

   // pins: strobe follows the strobe clock, data follows the bus clock
   assign strobeClk = modeLink ? strobePhaseClock : ckIn;
   assign rwdsOe = ~csN;
   // strobe enable moves on the strobe clock's rising edge, while the strobe is low,
   // so a burst that ends on a falling edge cannot leave a runt strobe pulse
   always_ff @(posedge strobeClk or posedge csN)
   begin
      if (csN)
         strobeEn <= 1'b0;
      else
         strobeEn <= next_dataPhase;
   end
   assign rwdsOut = strobeEn & ~strobeClk;
   assign dqOe = ~csN & (state == DFP_READ);
   assign dqOut = ckIn ? outWord[7:0] : outWord[15:8];

   // core side: synchronise select and toggles, decode request
   logic cs1, cs2, rq1, rq2, rqSeen, dr1, dr2, drSeen;
   logic next_reqValid, next_writeDrop;
   always_comb
   begin
      next_reqValid = rq2 ^ rqSeen;
      next_writeDrop = dr2 ^ drSeen;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cs1 <= 1'b1;
         cs2 <= 1'b1;
         rq1 <= 1'b0;
         rq2 <= 1'b0;
         rqSeen <= 1'b0;
         dr1 <= 1'b0;
         dr2 <= 1'b0;
         drSeen <= 1'b0;
         reqValid <= 1'b0;
         writeDrop <= 1'b0;
         reqRead <= 1'b0;
         reqSpace <= 1'b0;
         reqLinear <= 1'b0;
         reqAddr <= '0;
      end
      else
      begin
         cs1 <= csN;
         cs2 <= cs1;
         rq1 <= reqToggle;
         rq2 <= rq1;
         rqSeen <= rq2;
         dr1 <= dropToggle;
         dr2 <= dr1;
         drSeen <= dr2;
         reqValid <= next_reqValid;
         writeDrop <= next_writeDrop;
         // reqWord has been still for at least two core clock cycles here
         if (next_reqValid)
         begin
            reqRead <= reqWord[`DFP_CA_RW_BIT];
            reqSpace <= reqWord[`DFP_CA_SPACE_BIT];
            reqLinear <= reqWord[`DFP_CA_LINEAR_BIT];
            reqAddr <= reqWord[`DFP_ADDR_MSB:0];
         end
      end
   end
   assign frameActive = ~cs2;

   // read path: core pushes words tagged with the frame they answer
   dfp_fifo #(.WIDTH(TW), .DEPTH(DEPTH)) readFifo (
      .wClk(clk),
      .wRst(rst),
      .wValid(rdValid),
      .wReady(rdReady),
      .wData({rqSeen, rdData}),
      .rClk(ckFall),
      .rRst(rst),
      .rValid(lrValid),
      .rReady(popRd),
      .rData(lrData)
   );

   // write path: link pushes received words in linear order, except those a full fifo refuses or overlay state drops after the first
   dfp_fifo #(.WIDTH(`DFP_WORD_WIDTH), .DEPTH(DEPTH)) writeFifo (
      .wClk(ckFall),
      .wRst(rst),
      .wValid(pushWr),
      .wReady(lwReady),
      .wData(linkWord),
      .rClk(clk),
      .rRst(rst),
      .rValid(wrValid),
      .rReady(wrReady),
      .rData(wrData)
   );

   chk_write_strobe_low: assert property (@(posedge ckFall) disable iff (csN)
      (state == DFP_WRITE) |-> (rwdsOe && !dataPhase && !strobeEn))
      else $error("strobe not held low in a write frame");
   chk_read_pins_driven: assert property (@(posedge ckFall) disable iff (csN)
      dataPhase |-> (dqOe && rwdsOe))
      else $error("read data valid without driven pins");
   chk_latency_floor: assert property (@(posedge ckFall) disable iff (csN)
      $rose(state == DFP_LAT) |-> !dataPhase [*2])
      else $error("read data before the latency count");
   chk_latency_bound: assert property (@(posedge ckFall) disable iff (csN)
      (caDone && caShift[31]) |-> ##[1:16] (state == DFP_READ))
      else $error("read phase late after command");
   chk_word_per_clock: assert property (@(posedge ckFall) disable iff (csN)
      (state == DFP_READ && lrValid && tagOk) |=> (dataPhase && outWord == $past(lrData[TW-2:0])))
      else $error("ready word not presented on next strobe pair");
   chk_release_idle: assert property (@(posedge clk) disable iff (rst)
      (cs2 && csN) |-> (!dqOe && !rwdsOe))
      else $error("pins driven with select inactive");
   chk_write_linear: assert property (@(posedge clk) disable iff (rst)
      (reqValid && !reqRead) |-> reqLinear)
      else $error("write request not linear");
   chk_overlay_single: assert property (@(posedge ckFall) disable iff (csN)
      (state == DFP_WRITE && wrAny && ovlLink) |-> !pushWr ##1 (dropToggle != $past(dropToggle)))
      else $error("burst word accepted in overlay state");
   chk_req_pulse: assert property (@(posedge clk) disable iff (rst)
      reqValid |=> !reqValid)
      else $error("request pulse longer than one cycle");
endmodule : dfp_port

/* dfp_host_model.sv */
// host bus master model: link clock, chip select, command/address and write bytes
// assumes the testbench fills wq before a write frame and empties rq after a read
`timescale 1ns/1ps
module dfp_host_model
(
   // link pins towards the device
   output logic ckIn,
   output logic csN,
   output logic strobePhaseClock,
   output logic [7:0] dqIn,
   // device answer
   input wire logic [7:0] dqOut,
   input wire logic dqOe,
   input wire logic rwdsOut,
   input wire logic rwdsOe
);
   logic [15:0] wq[$];
   logic [15:0] rq[$];
   logic [7:0] hiByte;
   logic [7:0] dqBus;
   // no keeper on the bus: a released bus shows the inverse, so late drive is caught
   assign dqBus = dqOe ? dqOut : ~dqOut;
   // clock parked low, select idle, bus released
   initial
   begin
      ckIn = 1'b0;
      csN = 1'b1;
      strobePhaseClock = 1'b0;
      dqIn = 8'ha5;
   end
   // strobe clock trails the link clock by a quarter period, single-ended only
   always @(ckIn) strobePhaseClock <= #8 ckIn;
   // sample inside the data eye, since strobe and data move together unless phaseShiftedStrobeMode is set
   always @(posedge rwdsOut) if (rwdsOe) #4 hiByte = dqBus;
   always @(negedge rwdsOut) if (rwdsOe) #4 rq.push_back({hiByte, dqBus});
   // one link period: first byte before the rising edge, second before the falling
   task automatic linkWord(input logic [15:0] w);
      dqIn = w[15:8];
      #8 ckIn = 1'b1;
      #8 dqIn = w[7:0];
      #8 ckIn = 1'b0;
      #8;
   endtask : linkWord
   // whole frame; idle bytes toggle because a released bus shows no stable value
   task automatic frame(input logic [47:0] ca, input int idle);
      #43 ckIn = 1'b0;
      csN = 1'b0;
      #8;
      for (int i = 2; i >= 0; i--) linkWord(ca[16*i +: 16]);
      while (wq.size() > 0) linkWord(wq.pop_front());
      for (int i = 0; i < idle; i++) linkWord({~dqIn, dqIn});
      // extra clock on reads only: every falling edge of a write frame loads a word
      if (ca[47]) linkWord({~dqIn, dqIn});
      csN = 1'b1;
      dqIn = ~dqIn;
      #2;
   endtask : frame
endmodule : dfp_host_model

/* ddr_flash_bus_read_burst_write_port_tb.sv */
// testbench of the ddr flash host port: reads, burst writes, overlay drops, fifo fill
// assumes dfp_port, dfp_fifo and the host model are compiled alongside
`timescale 1ns/1ps
`include "dfp_defs.svh"
module ddr_flash_bus_read_burst_write_port_tb;
   logic clk, rst, ckIn, csN, strobePhaseClock, dqOe, rwdsOut, rwdsOe;
   logic [7:0] dqIn, dqOut;
   logic overlaySpaceState, phaseShiftedStrobeMode, reqValid, reqRead, reqSpace, reqLinear;
   logic [`DFP_ADDR_MSB:0] reqAddr;
   logic frameActive, writeDrop, rdValid, rdReady, wrValid, wrReady;
   logic [15:0] rdData, wrData;
   logic [47:0] reqSeen;
   logic [15:0] got[$];
   logic inWrite = 1'b0;
   int n_errors = 0;
   int comparisons = 0;
   int nDrop = 0;
   int nReq = 0;
   dfp_port #(.LINK_PERIOD_NS(32), .DEPTH(16)) dut (.clk(clk), .rst(rst), .ckIn(ckIn),
      .csN(csN), .strobePhaseClock(strobePhaseClock), .dqIn(dqIn), .dqOut(dqOut),
      .dqOe(dqOe), .rwdsOut(rwdsOut), .rwdsOe(rwdsOe), .overlaySpaceState(overlaySpaceState),
      .phaseShiftedStrobeMode(phaseShiftedStrobeMode), .reqValid(reqValid),
      .reqRead(reqRead), .reqSpace(reqSpace), .reqLinear(reqLinear), .reqAddr(reqAddr),
      .frameActive(frameActive), .writeDrop(writeDrop), .rdValid(rdValid),
      .rdReady(rdReady), .rdData(rdData), .wrValid(wrValid), .wrReady(wrReady),
      .wrData(wrData));
   dfp_host_model host (.ckIn(ckIn), .csN(csN), .strobePhaseClock(strobePhaseClock),
      .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .rwdsOut(rwdsOut), .rwdsOe(rwdsOe));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // core-side monitor: requests, drop pulses, accepted write words
   always @(posedge clk)
   begin
      if (reqValid === 1'b1)
      begin
         nReq++;
         reqSeen = {reqRead, reqSpace, reqLinear, reqAddr};
      end
      if (writeDrop === 1'b1) nDrop++;
      if (wrValid === 1'b1 && wrReady) got.push_back(wrData);
   end
   // strobe must stay driven low through a write frame, never a mask
   always @(negedge ckIn)
   begin
      if (inWrite && !csN)
      begin
         checkVal(rwdsOut, 0);
         checkVal(rwdsOe, 1);
      end
   end
   task automatic checkVal(input logic [47:0] g, input logic [47:0] e);
      comparisons++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : checkVal
   task automatic print_verdict;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   // read four words; core supplies them once the request is seen
   task automatic testRead(input logic mode);
      logic [47:0] ca;
      int k;
      ca = {2'b11, ~mode, 45'h12345};
      @(posedge clk);
      phaseShiftedStrobeMode <= mode;
      nReq = 0;
      fork
         host.frame(ca, 12);
         begin
            k = 0;
            while (nReq == 0 && k < 100)
            begin
               @(posedge clk);
               k++;
            end
            checkVal(frameActive, 1);
            for (int i = 0; i < 4; i++)
            begin
               rdValid <= 1'b1;
               rdData <= {12'hc0d, i[3:0]};
               @(posedge clk);
               checkVal(rdReady, 1);
            end
            rdValid <= 1'b0;
         end
      join
      checkVal(dqOe, 0);
      checkVal(rwdsOe, 0);
      checkVal(nReq, 1);
      checkVal(reqSeen, ca);
      checkVal(host.rq.size(), 4);
      for (int i = 0; i < 4; i++) checkVal(host.rq.pop_front(), {12'hc0d, i[3:0]});
      repeat (3) @(posedge clk);
      checkVal(frameActive, 0);
   endtask : testRead
   // linear burst write; a stalled core lets the fifo fill until it refuses
   task automatic testWrite(input logic ovl, input int nw, input int nOut, input logic stall);
      logic [47:0] ca;
      int k;
      ca = {3'b001, 45'h200 + nw};
      @(posedge clk);
      overlaySpaceState <= ovl;
      wrReady <= !stall;
      got.delete();
      nDrop = 0;
      for (int i = 0; i < nw; i++) host.wq.push_back({8'h5a, i[7:0]});
      inWrite = 1'b1;
      host.frame(ca, 0);
      inWrite = 1'b0;
      repeat (20) @(posedge clk);
      wrReady <= 1'b1;
      k = 0;
      while (got.size() < nOut && k < 300)
      begin
         @(posedge clk);
         k++;
      end
      if (got.size() < nOut)
      begin
         n_errors++;
         print_verdict();
      end
      repeat (10) @(posedge clk);
      checkVal(got.size(), nOut);
      checkVal(nDrop, nw - nOut);
      checkVal(reqSeen, ca);
      checkVal(wrValid, 0);
      for (int i = 0; i < nOut; i++) checkVal(got[i], {8'h5a, i[7:0]});
   endtask : testWrite
   // main sequence
   initial
   begin
      rst = 1'b1;
      rdValid = 1'b0;
      rdData = 16'h0000;
      wrReady = 1'b0;
      overlaySpaceState = 1'b0;
      phaseShiftedStrobeMode = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      testRead(1'b0);
      testRead(1'b1);
      testWrite(1'b0, 5, 5, 1'b0);
      testWrite(1'b1, 3, 1, 1'b0);
      testWrite(1'b0, 18, 16, 1'b1);
      print_verdict();
   end
endmodule : ddr_flash_bus_read_burst_write_port_tb
